// file: rtl/ehci_schedule_pointer_regs.sv
// Purpose: Periodic base, asynchronous pointer and port routing flag registers.
// Assumes: Register access strobes are synchronous to mclk_in, one cycle each.
// Notes: Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module ehci_schedule_pointer_regs
	import sched_ptr_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Register access port.
	input wire reg_access_t reg_acc_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_hit_out,
	// Schedule context from the rest of the controller.
	input wire logic [13:0] microframe_counter_in,
	input wire logic [1:0] list_size_select_in,
	input wire logic wide_addressing_capable_in,
	input wire logic [31:0] data_structure_segment_in,
	// Addresses presented to the schedule engines.
	output var wide_addr_t periodic_entry_addr_out,
	output var wide_addr_t async_qh_addr_out,
	// Port routing.
	output logic port_routing_select_out
);
	// Stored base address bits 31 to 12.
	logic [19:0] periodic_base_r;
	// Stored queue head pointer bits 31 to 5.
	logic [26:0] queue_head_link_field_r;
	// Port routing flag.
	logic port_routing_select_r;
	// Selected frame list index, as entry number.
	logic [9:0] entry_index;
	// Low 12 address bits of the current entry.
	logic [11:0] entry_offset;
	// Upper address word, zero unless wide addressing is supported.
	logic [31:0] upper_word;

	// Upper word selection shared by both address outputs.
	function automatic logic [31:0] upper_sel(input logic wide, input logic [31:0] seg);
		upper_sel = wide ? seg : 32'h0000_0000;
	endfunction : upper_sel

	// Periodic base register; only bits 31 to 12 are storage.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			periodic_base_r <= periodic_base_rst[31:periodic_base_lsb];
		end else if (reg_acc_in.wr && reg_acc_in.addr == periodic_base_off) begin
			periodic_base_r <= reg_acc_in.wdata[31:periodic_base_lsb];
		end
	end

	// Asynchronous pointer; low five bits are simply not stored.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			queue_head_link_field_r <= async_ptr_rst[31:async_ptr_lsb];
		end else if (reg_acc_in.wr && reg_acc_in.addr == async_ptr_off) begin
			queue_head_link_field_r <= reg_acc_in.wdata[31:async_ptr_lsb];
		end
	end

	// Routing flag; resets so ports start on the companion controller.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			port_routing_select_r <= routing_flag_rst;
		end else if (reg_acc_in.wr && reg_acc_in.addr == routing_flag_off) begin
			port_routing_select_r <= reg_acc_in.wdata[routing_select_bit];
		end
	end

	// Pick index bits N down to 3; the reserved size code falls back to 1024.
	always_comb begin
		case (list_size_select_in)
			list_size_512: begin
				entry_index = {1'b0, microframe_counter_in[11:3]};
			end
			list_size_256: begin
				entry_index = {2'b00, microframe_counter_in[10:3]};
			end
			default: begin
				entry_index = microframe_counter_in[12:3];
			end
		endcase
		// Each entry is a 4-byte pointer within the 4 kB page.
		entry_offset = {entry_index, 2'b00};
		upper_word = upper_sel(wide_addressing_capable_in, data_structure_segment_in);
	end

	// Addresses are registered so the schedule engines see clean values.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			periodic_entry_addr_out <= '0;
			async_qh_addr_out <= '0;
		end else begin
			periodic_entry_addr_out.upper <= upper_word;
			periodic_entry_addr_out.lower <= {periodic_base_r, entry_offset};
			async_qh_addr_out.upper <= upper_word;
			async_qh_addr_out.lower <= {queue_head_link_field_r, 5'h00};
		end
	end

	// Read mux; unmapped offsets read zero and drop the hit flag.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 32'h0000_0000;
			reg_hit_out <= 1'b0;
		end else if (reg_acc_in.rd) begin
			case (reg_acc_in.addr)
				periodic_base_off: begin
					reg_rdata_out <= {periodic_base_r, 12'h000};
					reg_hit_out <= 1'b1;
				end
				async_ptr_off: begin
					reg_rdata_out <= {queue_head_link_field_r, 5'h00};
					reg_hit_out <= 1'b1;
				end
				routing_flag_off: begin
					reg_rdata_out <= {31'h0000_0000, port_routing_select_r};
					reg_hit_out <= 1'b1;
				end
				default: begin
					reg_rdata_out <= 32'h0000_0000;
					reg_hit_out <= 1'b0;
				end
			endcase
		end else begin
			reg_hit_out <= 1'b0;
		end
	end

	// The flag goes straight out; routing logic reads it as a level.
	assign port_routing_select_out = port_routing_select_r;

	// Write to base lands in bits 31 to 12 the next cycle.
	a_base_write: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.wr && reg_acc_in.addr == periodic_base_off |=>
		periodic_base_r == $past(reg_acc_in.wdata[31:12]))
		else $error("periodic base did not capture write");
	// Base read shows the stored bits and zeros below bit 12.
	a_base_readback: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.rd && reg_acc_in.addr == periodic_base_off |=>
		reg_rdata_out == {$past(periodic_base_r), 12'h000})
		else $error("periodic base readback wrong");
	// Async read always has zero low bits.
	a_async_low_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.rd && reg_acc_in.addr == async_ptr_off |=> reg_rdata_out[4:0] == 5'h00)
		else $error("async pointer low bits not zero");
	// Async read returns the last written upper bits.
	a_async_readback: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.wr && reg_acc_in.addr == async_ptr_off ##1
		(reg_acc_in.rd && reg_acc_in.addr == async_ptr_off && !reg_acc_in.wr) |=>
		reg_rdata_out[31:5] == $past(reg_acc_in.wdata[31:5], 2))
		else $error("async pointer readback wrong");
	// The queue head address reaches the engine two cycles after the write.
	a_async_addr: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.wr && reg_acc_in.addr == async_ptr_off ##1
		!(reg_acc_in.wr && reg_acc_in.addr == async_ptr_off) |=>
		async_qh_addr_out.lower == {$past(reg_acc_in.wdata[31:5], 2), 5'h00})
		else $error("queue head address does not follow pointer write");
	// Routing flag read shows zero in reserved bits.
	// A write in the same cycle is not yet visible, so the old flag is expected.
	a_flag_reserved: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.rd && reg_acc_in.addr == routing_flag_off |=>
		reg_rdata_out[31:1] == 31'h0 &&
		reg_rdata_out[0] == $past(port_routing_select_out))
		else $error("routing flag read wrong");
	// Routing output follows a flag write.
	a_flag_route: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.wr && reg_acc_in.addr == routing_flag_off |=>
		port_routing_select_out == $past(reg_acc_in.wdata[0]))
		else $error("routing output did not follow write");
	// Without a flag write the routing output holds its level.
	a_flag_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!(reg_acc_in.wr && reg_acc_in.addr == routing_flag_off) |=>
		$stable(port_routing_select_out))
		else $error("routing output changed without a write");
	// Reset returns ports to the companion and clears the hit flag and both addresses.
	a_reset_clear: assert property (@(posedge mclk_in)
		sys_rst_in |=> !port_routing_select_out && !reg_hit_out &&
		periodic_entry_addr_out == '0 && async_qh_addr_out == '0)
		else $error("outputs not cleared by reset");
	// Quarter-size list uses index bits 10 down to 3.
	a_entry_index: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		list_size_select_in == list_size_256 |=>
		periodic_entry_addr_out.lower[11:2] == {2'b00, $past(microframe_counter_in[10:3])})
		else $error("entry index wrong for 256 entries");
	// Half-size list uses index bits 11 down to 3.
	a_entry_512: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		list_size_select_in == list_size_512 |=>
		periodic_entry_addr_out.lower[11:2] == {1'b0, $past(microframe_counter_in[11:3])})
		else $error("entry index wrong for 512 entries");
	// Full-size list uses index bits 12 down to 3.
	a_entry_1024: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		list_size_select_in == list_size_1024 |=>
		periodic_entry_addr_out.lower[11:2] == $past(microframe_counter_in[12:3]))
		else $error("entry index wrong for 1024 entries");
	// Entry address base matches the base stored one cycle earlier.
	a_entry_base: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		$stable(periodic_base_r) |=>
		periodic_entry_addr_out.lower[31:12] == $past(periodic_base_r))
		else $error("entry address base mismatch");
	// Upper address word of both addresses is zero without the wide mode capability.
	a_upper_word: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!wide_addressing_capable_in |=> async_qh_addr_out.upper == 32'h0 &&
		periodic_entry_addr_out.upper == 32'h0)
		else $error("upper word not zero in narrow mode");
	// In wide mode both addresses carry the segment word on top.
	a_upper_wide: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wide_addressing_capable_in |=>
		async_qh_addr_out.upper == $past(data_structure_segment_in) &&
		periodic_entry_addr_out.upper == $past(data_structure_segment_in))
		else $error("upper word not taken from segment in wide mode");
	// Unmapped read gives no hit.
	a_unmapped: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.rd && reg_acc_in.addr != periodic_base_off &&
		reg_acc_in.addr != async_ptr_off && reg_acc_in.addr != routing_flag_off |=>
		!reg_hit_out && reg_rdata_out == 32'h0)
		else $error("unmapped read answered");
	// Mapped read always raises the hit flag.
	a_hit_mapped: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.rd && (reg_acc_in.addr == periodic_base_off ||
		reg_acc_in.addr == async_ptr_off || reg_acc_in.addr == routing_flag_off) |=>
		reg_hit_out)
		else $error("mapped read gave no hit");

	// Main scenarios that the bench is expected to reach.
	c_flag_set: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		$rose(port_routing_select_out));
	c_async_read: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.rd && reg_acc_in.addr == async_ptr_off);
	c_wide_mode: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		wide_addressing_capable_in && periodic_base_r != 20'h0);
	c_size_256: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		list_size_select_in == list_size_256 && microframe_counter_in[10:3] != 8'h00);
	c_same_cycle: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		reg_acc_in.wr && reg_acc_in.rd);
endmodule : ehci_schedule_pointer_regs
`default_nettype wire

// file: rtl/sched_ptr_pkg.sv
// Purpose: Shared constants and types for the schedule pointer register bank.
// Assumes: 32-bit register access at byte offsets from the controller base.
// Notes: Offsets are byte addresses within the operational register space.
package sched_ptr_pkg;
	// Register byte offsets.
	localparam logic [7:0] periodic_base_off = 8'h34;
	localparam logic [7:0] async_ptr_off = 8'h38;
	localparam logic [7:0] routing_flag_off = 8'h60;
	// Values after reset.
	localparam logic [31:0] periodic_base_rst = 32'h0000_0000;
	localparam logic [31:0] async_ptr_rst = 32'h0000_0000;
	localparam logic routing_flag_rst = 1'h0;
	// Field positions.
	localparam int periodic_base_lsb = 12;
	localparam int async_ptr_lsb = 5;
	localparam int routing_select_bit = 0;
	// List size select encodings.
	localparam logic [1:0] list_size_1024 = 2'h0;
	localparam logic [1:0] list_size_512 = 2'h1;
	localparam logic [1:0] list_size_256 = 2'h2;

	// One register access from the host bus.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_access_t;

	// Full address of a control data structure.
	typedef struct packed {
		logic [31:0] upper;
		logic [31:0] lower;
	} wide_addr_t;
endpackage : sched_ptr_pkg

// file: test/host_sw_model.sv
// Purpose: Host software that programs the schedule pointers in order.
// Assumes: The bank takes one strobe per cycle with no wait.
// Notes: Values are aligned and reserved bits are written as zero.
`timescale 1ns/10ps
`default_nettype none
module host_sw_model
	import sched_ptr_pkg::*;
#(
	parameter logic [31:0] base_val = 32'h0003_7000,
	parameter logic [31:0] qh_val = 32'h0000_5a40
) (
	// Clock and sequence control.
	input wire logic mclk_in,
	input wire logic go_in,
	// Access request and completion.
	output var reg_access_t acc_out,
	output logic done_out
);
	logic [1:0] step_r; // Position in the set-up sequence.
	// The flag goes last, so ports move only once both lists are in place.
	always_ff @(posedge mclk_in) begin
		if (!go_in) begin
			step_r <= 2'h0;
			acc_out <= '0;
			done_out <= 1'b0;
		end else begin
			if (step_r != 2'h3) begin
				step_r <= step_r + 2'h1;
			end
			case (step_r)
				2'h0: acc_out <= {1'b1, 1'b0, periodic_base_off,
					base_val};
				2'h1: acc_out <= {1'b1, 1'b0, async_ptr_off,
					qh_val};
				2'h2: acc_out <= {1'b1, 1'b0, routing_flag_off, 32'h0000_0001};
				default: begin
					acc_out <= '0;
					done_out <= 1'b1;
				end
			endcase
		end
	end
endmodule : host_sw_model
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the schedule pointer registers.
// Assumes: Strobes last one cycle; read answers come one cycle later.
// Notes: A monitor pops one expected word for every read taken.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sched_ptr_pkg::*;
	localparam logic [31:0] host_base = 32'h0003_7000;
	logic mclk_in = 1'b0; // Bench clock.
	logic sys_rst_in = 1'b1; // Held for the first ten edges.
	reg_access_t tb_acc = '0; // Bench request.
	reg_access_t host_acc; // Host model request.
	reg_access_t acc; // Request that reaches the bank.
	logic go = 1'b0;
	logic done;
	logic [13:0] mf = '0;
	logic [1:0] sz = '0;
	logic wide = 1'b0;
	logic [31:0] seg = '0;
	logic [31:0] rdata;
	logic hit;
	logic route;
	logic rd_q = 1'b0; // A read was taken at the last edge.
	wide_addr_t per_addr;
	wide_addr_t qh_addr;
	logic [32:0] exp_q[$]; // Expected hit flag and read word.
	logic [31:0] rng = 32'h0000_fd1f;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	assign acc = go ? host_acc : tb_acc;
	always #5 mclk_in = ~mclk_in;
	host_sw_model #(.base_val(host_base), .qh_val(32'h0000_5a40)) host (.mclk_in(mclk_in),
		.go_in(go), .acc_out(host_acc), .done_out(done));
	ehci_schedule_pointer_regs uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.reg_acc_in(acc), .reg_rdata_out(rdata), .reg_hit_out(hit),
		.microframe_counter_in(mf), .list_size_select_in(sz),
		.wide_addressing_capable_in(wide), .data_structure_segment_in(seg),
		.periodic_entry_addr_out(per_addr), .async_qh_addr_out(qh_addr),
		.port_routing_select_out(route));
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check
	// The strobe is not lowered here, so back-to-back calls never clash.
	task automatic op(input logic w, input logic r, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		tb_acc <= {w, r, a, d};
		if (r) begin
			exp_q.push_back(e);
		end
		@(posedge mclk_in);
	endtask : op
	task automatic idle(input int n);
		tb_acc <= '0;
		repeat (n) @(posedge mclk_in);
	endtask : idle
	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	// Read answers appear one edge after the read is taken.
	always @(posedge mclk_in) begin
		if (rd_q) begin
			check({31'h0, hit, rdata}, {31'h0, exp_q.pop_front()});
		end
		rd_q <= acc.rd & ~sys_rst_in;
		cycles++;
		if (cycles > 1000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		logic [31:0] b, p, r, s;
		logic [9:0] m;
		repeat (10) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		check({63'h0, route}, 64'h0);
		op(1'b0, 1'b1, periodic_base_off, '0, {1'b1, periodic_base_rst});
		op(1'b0, 1'b1, routing_flag_off, '0, 33'h1_0000_0000);
		op(1'b1, 1'b1, async_ptr_off, 32'hffff_ffff, {1'b1, async_ptr_rst});
		op(1'b0, 1'b1, async_ptr_off, '0, 33'h1_ffff_ffe0);
		op(1'b1, 1'b0, routing_flag_off, 32'hffff_fffe, '0);
		op(1'b0, 1'b1, routing_flag_off, '0, 33'h1_0000_0000);
		for (int i = 0; i < 8; i++) begin
			b = rnd();
			p = rnd();
			r = rnd();
			s = rnd();
			m = (i % 4 == 1) ? 10'h1ff : ((i % 4 == 2) ? 10'h0ff : 10'h3ff);
			mf <= r[13:0];
			sz <= 2'(i);
			wide <= i[2];
			seg <= s;
			op(1'b1, 1'b0, periodic_base_off, b, '0);
			op(1'b1, 1'b0, async_ptr_off, p, '0);
			op(1'b1, 1'b0, 8'h3c, r, '0);
			op(1'b0, 1'b1, periodic_base_off, '0, {1'b1, b[31:12], 12'h0});
			op(1'b0, 1'b1, 8'h3c, '0, 33'h0);
			idle(2);
			check(per_addr, {(i[2] ? s : 32'h0), b[31:12], r[12:3] & m, 2'h0});
			check(qh_addr, {(i[2] ? s : 32'h0), p[31:5], 5'h0});
		end
		go <= 1'b1;
		for (int k = 0; k < 20 && done !== 1'b1; k++) begin
			@(posedge mclk_in);
		end
		go <= 1'b0;
		check({63'h0, route}, 64'h1);
		op(1'b0, 1'b1, routing_flag_off, '0, 33'h1_0000_0001);
		op(1'b0, 1'b1, periodic_base_off, '0, {1'b1, host_base});
		op(1'b1, 1'b0, routing_flag_off, 32'h0000_0000, '0);
		idle(1);
		check({63'h0, route}, 64'h0);
		// Set the flag again, then pull reset in mid-run: all state must clear.
		op(1'b1, 1'b0, routing_flag_off, 32'h0000_0001, '0);
		sys_rst_in <= 1'b1;
		idle(2);
		sys_rst_in <= 1'b0;
		check({63'h0, route}, 64'h0);
		check(per_addr, 64'h0);
		check(qh_addr, 64'h0);
		op(1'b0, 1'b1, periodic_base_off, '0, {1'b1, periodic_base_rst});
		op(1'b0, 1'b1, routing_flag_off, '0, 33'h1_0000_0000);
		idle(3);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
